// File: verilog/ocd_pkg.sv
// Operation
// [RQ1] Halted core runs from debug link clock
// [RQ2] TCK or two-pin clock per active link
// [RQ3] Halted forces refresh period to 0x10
// [RQ4] Halt stops peripherals, serial, timers, PWM
// [RQ5] Four comparators: two address, two value
// [RQ6] Active breakpoints all one type
// [RQ7] Data breakpoints share one memory area
// [RQ8] Address range allows only one breakpoint
// [RQ9] Only listed comparator combinations accepted
// [RQ10] Two-pin link clock rides reset pin
// [RQ11] Two-pin link half-duplex synchronous
// [RQ12] Both links reach one debug unit
// [RQ13] One reserved comparator, unlimited BREAK; no comparator is reserved here, all four come from the ports
// [RQ14] Works at any system clock frequency; link edges are oversampled, so core_clk must run well above the link clock
// [RQ15] Debugger drives TCK TMS TDI, samples TDO
// [RQ16] Match halts core and reports halt
package ocd_pkg;
  localparam logic [7:0] REFRESH_HALT   = 8'h10;
  localparam int         FRAME_BITS     = 8;
  localparam int         CMD_POS        = 4;
  localparam logic [3:0] CMD_HALT       = 4'h1;
  localparam logic [3:0] CMD_RUN        = 4'h2;
  localparam logic [3:0] CMD_CFG        = 4'h3;
  localparam logic [3:0] CMD_STATUS     = 4'h4;
  // Config nibble: [3] range, [2] data type, [1:0] area
  localparam int         CFG_RANGE_POS  = 3;
  localparam int         CFG_DATA_POS   = 2;
  localparam logic [1:0] AREA_IO        = 2'h0;
  localparam logic [1:0] AREA_SRAM      = 2'h1;
  localparam logic [1:0] AREA_EXT       = 2'h2;
  localparam int         CLK_DIV        = 4;
endpackage

// File: verilog/ocd_link_if.sv
interface ocd_link_if;
  logic linkClk;
  logic dataHost;
  logic dataHostOe;
  logic dataDev;
  logic dataDevOe;
  logic linkData;
  assign linkData = dataHostOe ? dataHost : (dataDevOe ? dataDev : 1'b1);
  modport device (input linkClk, input linkData, output dataDev, output dataDevOe);
  modport host   (output linkClk, output dataHost, output dataHostOe, input linkData);
endinterface

// File: verilog/ocd_device.sv
module ocd_device (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  ocd_link_if.device       link,
  input  wire logic        jtagSelect,
  input  wire logic        tck,
  input  wire logic        jtagCmdValid,
  input  wire logic [7:0]  jtagCmd,
  input  wire logic [15:0] addrBus,
  input  wire logic [7:0]  dataBus,
  input  wire logic        dataAccess,
  input  wire logic [1:0]  dataArea,
  input  wire logic        breakInsn,
  input  wire logic [15:0] cmpAddr0,
  input  wire logic [15:0] cmpAddr1,
  input  wire logic [7:0]  cmpVal0,
  input  wire logic [7:0]  cmpVal1,
  input  wire logic [1:0]  addrEnable,
  input  wire logic        valEnable,
  input  wire logic [7:0]  userRefresh,
  output logic             coreHalted,
  output logic             useLinkClk,
  output logic             debugClkSel,
  output logic [7:0]       refreshPeriod,
  output logic             periphStop,
  output logic             cfgError
);
  // ==========================
  // Link clock sampling
  // ==========================
  logic clkS1, clkS2, clkS3, datS1, datS2, tckS1, tckS2;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {clkS1, clkS2, clkS3, datS1, datS2, tckS1, tckS2} <= 7'h00;
    end else begin
      clkS1 <= link.linkClk; // [RQ10]
      clkS2 <= clkS1;
      clkS3 <= clkS2;
      datS1 <= link.linkData;
      datS2 <= datS1;
      tckS1 <= tck;
      tckS2 <= tckS1;
    end
  end
  // Edge found from oversampling, so any core clock rate well above link rate works
  wire clkRise = clkS2 & ~clkS3; // [RQ14]
  wire clkFall = ~clkS2 & clkS3;
  // ==========================
  // Half-duplex frame engine
  // ==========================
  typedef enum {ST_RX, ST_TX} ocd_dir_e;
  ocd_dir_e    dir_r;
  logic [2:0]  bitCnt_r;
  logic [7:0]  shift_r;
  logic        rxDone;
  logic [7:0]  txByte;
  logic        txReq;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_r    <= ST_RX;
      bitCnt_r <= 3'h0;
      shift_r  <= 8'h00;
      rxDone   <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      case (dir_r)
        ST_RX: begin
          if (clkRise) begin // [RQ11]
            shift_r  <= {shift_r[6:0], datS2};
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7) begin
              rxDone <= 1'b1;
            end
          end
          if (txReq) begin
            dir_r    <= ST_TX;
            shift_r  <= txByte;
            bitCnt_r <= 3'h0;
          end
        end
        ST_TX: begin
          if (clkFall && bitCnt_r != 3'h0) begin
            shift_r <= {shift_r[6:0], 1'b0};
          end
          if (clkRise) begin
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7) begin
              dir_r <= ST_RX;
            end
          end
        end
        default: dir_r <= ST_RX;
      endcase
    end
  end
  assign link.dataDev   = shift_r[7];
  assign link.dataDevOe = (dir_r == ST_TX); // [RQ11]
  // ==========================
  // Shared debug unit
  // ==========================
  wire       cmdValid = jtagSelect ? jtagCmdValid : rxDone; // [RQ12]
  wire [7:0] rxWord   = shift_r;
  wire [7:0] cmdByte  = jtagSelect ? jtagCmd : rxWord;
  wire [3:0] cmdOp    = (jtagSelect ? jtagCmd[7:4] : rxWord[7:4]);
  wire [3:0] cmdArg   = (jtagSelect ? jtagCmd[3:0] : rxWord[3:0]);
  logic       halted_r, haltNew_r, cfgRange_r, cfgData_r, cfgErr_r;
  logic [1:0] cfgArea_r;
  wire addr0Hit = addrEnable[0] && addrBus == cmpAddr0;
  wire addr1Hit = addrEnable[1] && addrBus == cmpAddr1;
  wire inRange  = addrBus >= cmpAddr0 && addrBus <= cmpAddr1;
  wire valHit   = !valEnable || (cfgRange_r ? (dataBus >= cmpVal0 && dataBus <= cmpVal1) : dataBus == cmpVal0);
  wire areaOk   = !cfgData_r || (dataAccess && dataArea == cfgArea_r); // [RQ7]
  wire typeOk   = cfgData_r == dataAccess; // [RQ6]
  wire addrHit  = cfgRange_r ? (addrEnable != 2'h0 && inRange) : (addr0Hit | addr1Hit); // [RQ9]
  wire hwHit    = typeOk && areaOk && addrHit && (cfgData_r ? valHit : 1'b1); // [RQ5]
  // Range mode takes both address comparators, so a second breakpoint is refused
  wire cfgBad   = (cfgRange_r && addrEnable != 2'h3 && addrEnable != 2'h0)
                  || (!cfgData_r && valEnable)
                  || (cfgData_r && cfgArea_r == 2'h3); // [RQ8]
  wire validCfg = !cfgBad;
  // BREAK instruction halts directly and needs no comparator
  wire brkHit   = breakInsn || (validCfg && hwHit); // [RQ13]
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      halted_r   <= 1'b0;
      haltNew_r  <= 1'b0;
      cfgRange_r <= 1'b0;
      cfgData_r  <= 1'b0;
      cfgArea_r  <= ocd_pkg::AREA_IO;
      cfgErr_r   <= 1'b0;
    end else begin
      cfgErr_r <= cfgBad;
      // Clear first so a hit in the same cycle wins
      if (txReq) begin
        haltNew_r <= 1'b0;
      end
      if (!halted_r && brkHit) begin
        halted_r  <= 1'b1; // [RQ16]
        haltNew_r <= 1'b1;
      end else if (cmdValid && cmdOp == ocd_pkg::CMD_HALT) begin
        halted_r  <= 1'b1;
      end else if (cmdValid && cmdOp == ocd_pkg::CMD_RUN) begin
        halted_r  <= 1'b0;
      end
      if (cmdValid && cmdOp == ocd_pkg::CMD_CFG) begin
        cfgRange_r <= cmdArg[ocd_pkg::CFG_RANGE_POS];
        cfgData_r  <= cmdArg[ocd_pkg::CFG_DATA_POS];
        cfgArea_r  <= cmdArg[1:0];
      end
    end
  end
  assign txReq  = !jtagSelect && cmdValid && cmdOp == ocd_pkg::CMD_STATUS && cmdByte != 8'hFF;
  assign txByte = {ocd_pkg::CMD_STATUS, 1'b0, cfgErr_r, haltNew_r, halted_r};
  assign coreHalted    = halted_r;
  assign useLinkClk    = halted_r; // [RQ1]
  assign debugClkSel   = jtagSelect ? tckS2 : clkS2; // [RQ2]
  assign refreshPeriod = halted_r ? ocd_pkg::REFRESH_HALT : userRefresh; // [RQ3]
  assign periphStop    = halted_r; // [RQ4]
  assign cfgError      = cfgErr_r;
endmodule // ocd_device

// File: verilog/ocd_host.sv
module ocd_host (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  ocd_link_if.host        link,
  input  wire logic       sendValid,
  input  wire logic [7:0] sendByte,
  input  wire logic       expectReply,
  output logic            busy,
  output logic            replyValid,
  output logic [7:0]      replyByte
);
  // ==========================
  // Clock divider and framing
  // ==========================
  typedef enum {H_IDLE, H_TX, H_RX} ocd_host_e;
  ocd_host_e  st_r;
  logic [1:0] div_r;
  logic       clk_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic       exp_r, rv_r;
  logic       d1, d2;
  wire        tickFall = div_r == 2'h3 && clk_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r  <= H_IDLE;
      div_r <= 2'h0;
      clk_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      exp_r <= 1'b0;
      rv_r  <= 1'b0;
      d1    <= 1'b1;
      d2    <= 1'b1;
    end else begin
      d1    <= link.linkData;
      d2    <= d1;
      rv_r  <= 1'b0;
      div_r <= div_r + 2'h1;
      if (st_r != H_IDLE && div_r == 2'h3) begin
        clk_r <= ~clk_r; // [RQ10]
      end
      case (st_r)
        H_IDLE: begin
          clk_r <= 1'b0;
          if (sendValid) begin
            st_r  <= H_TX;
            sh_r  <= sendByte;
            cnt_r <= 4'h0;
            exp_r <= expectReply;
          end
        end
        H_TX: begin
          if (tickFall) begin
            sh_r <= {sh_r[6:0], 1'b0};
            if (cnt_r == 4'h7) begin
              cnt_r <= 4'h0;
              st_r  <= exp_r ? H_RX : H_IDLE; // [RQ11]
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        H_RX: begin
          if (tickFall) begin
            sh_r  <= {sh_r[6:0], d2};
            cnt_r <= cnt_r + 4'h1;
            // Eight falls take the eight reply bits; a ninth would shift in idle
            if (cnt_r == 4'h7) begin
              st_r <= H_IDLE;
              rv_r <= 1'b1;
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
  assign link.linkClk    = clk_r;
  assign link.dataHost   = sh_r[7];
  assign link.dataHostOe = (st_r == H_TX); // [RQ11]
  assign busy            = st_r != H_IDLE;
  assign replyValid      = rv_r;
  assign replyByte       = sh_r;
endmodule // ocd_host

// File: bench/ocd_link_sva.sv
module ocd_link_sva (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       dataHostOe,
  input wire logic       dataDevOe,
  input wire logic       coreHalted,
  input wire logic       useLinkClk,
  input wire logic       periphStop,
  input wire logic       breakInsn,
  input wire logic [7:0] refreshPeriod,
  input wire logic [7:0] userRefresh
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Stopped mode
  AST_REFRESH_HALT: assert property (coreHalted |-> refreshPeriod == ocd_pkg::REFRESH_HALT)
    else $error("refresh not forced");
  AST_REFRESH_RUN: assert property (!coreHalted |-> refreshPeriod == userRefresh)
    else $error("refresh not user value");
  AST_LINK_CLK: assert property (useLinkClk == coreHalted)
    else $error("clock source wrong");
  AST_PERIPH_STOP: assert property (periphStop == coreHalted)
    else $error("peripheral stop wrong");
  AST_BREAK_HALT: assert property (breakInsn |-> ##[1:4] coreHalted)
    else $error("break did not halt");
  // ==========================================
  // Link, one talker at a time
  AST_HALF_DUPLEX: assert property (!(dataHostOe && dataDevOe))
    else $error("both ends drive");
  AST_HOST_FRAME: assert property ($rose(dataHostOe) |-> dataHostOe [*8])
    else $error("host frame cut");
  AST_DEV_FRAME: assert property ($rose(dataDevOe) |-> dataDevOe [*8])
    else $error("reply frame cut");
endmodule // ocd_link_sva

// File: bench/tb_ocd_stop_mode_breakpoints.sv
module tb_ocd_stop_mode_breakpoints;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, reset_n = 0, jtagSelect = 0, tck = 0, jtagCmdValid = 0, dataAccess = 0;
  logic        breakInsn = 0, valEnable = 0, sendValid = 0, expectReply = 0, busy, replyValid;
  logic        coreHalted, useLinkClk, debugClkSel, periphStop, cfgError;
  logic [7:0]  jtagCmd = 0, dataBus = 0, cmpVal0 = 8'hA5, cmpVal1 = 0, userRefresh = 8'h5A, sendByte = 0;
  logic [7:0]  replyByte, refreshPeriod;
  logic [15:0] addrBus = 0, cmpAddr0 = 16'h0123, cmpAddr1 = 0;
  logic [1:0]  dataArea = 0, addrEnable = 0;
  int          n_errors = 0, n_checks = 0;
  ocd_link_if lnk ();
  ocd_device u_ocd_device (.core_clk, .reset_n, .link(lnk), .jtagSelect, .tck, .jtagCmdValid, .jtagCmd,
    .addrBus, .dataBus, .dataAccess, .dataArea, .breakInsn, .cmpAddr0, .cmpAddr1, .cmpVal0, .cmpVal1,
    .addrEnable, .valEnable, .userRefresh, .coreHalted, .useLinkClk, .debugClkSel, .refreshPeriod,
    .periphStop, .cfgError);
  ocd_host u_ocd_host (.core_clk, .reset_n, .link(lnk), .sendValid, .sendByte, .expectReply, .busy,
    .replyValid, .replyByte);
  ocd_link_sva u_ocd_link_sva (.core_clk, .reset_n, .dataHostOe(lnk.dataHostOe), .dataDevOe(lnk.dataDevOe),
    .coreHalted, .useLinkClk, .periphStop, .breakInsn, .refreshPeriod, .userRefresh);
  initial forever #4 core_clk = ~core_clk;
  // Free running at one eighth of the core_clk rate, edges on core_clk falling edges
  initial forever #32 tck = ~tck;
  // ==========================================
  // Helpers
  task finish_test();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task send(input logic [7:0] b, input logic r);
    int i;
    @(posedge core_clk);
    sendByte <= b;
    expectReply <= r;
    sendValid <= 1'b1;
    @(posedge core_clk);
    sendValid <= 1'b0;
    // Let the host leave idle before busy is trusted
    #1;
    for (i = 0; i < 400 && !(r ? replyValid === 1'b1 : busy === 1'b0); i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(i < 400, "link frame hung");
    if (i >= 400) finish_test();
    for (i = 0; i < 400 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(i < 400, "link idle hung");
    if (i >= 400) finish_test();
  endtask
  task status(input logic err, input logic h);
    send(8'h40, 1'b1);
    chk({replyByte[7:2], replyByte[0]} === {4'h4, 1'b0, err, h}, "status byte");
  endtask
  task waitHalt(input logic h, input string m);
    int i;
    for (i = 0; i < 50 && coreHalted !== h; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(coreHalted === h, m);
    if (coreHalted !== h) finish_test();
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    status(1'b0, 1'b0);
    chk(refreshPeriod === 8'h5A, "refresh run");
    send(8'h11, 1'b0);
    chk(useLinkClk === 1'b1 && periphStop === 1'b1, "halt state");
    userRefresh <= 8'h33;
    #8 chk(refreshPeriod === 8'h10, "refresh forced");
    status(1'b0, 1'b1);
    send(8'h21, 1'b0);
    chk(coreHalted === 1'b0 && refreshPeriod === 8'h33, "run state");
    jtagSelect <= 1'b1;
    jtagCmd <= 8'h11;
    jtagCmdValid <= 1'b1;
    @(posedge core_clk) jtagCmdValid <= 1'b0;
    waitHalt(1'b1, "tap halt");
    @(posedge tck);
    #30 chk(debugClkSel === tck, "tap clock select");
    jtagSelect <= 1'b0;
    send(8'h21, 1'b0);
    send(8'h30, 1'b0);
    addrEnable <= 2'b01;
    addrBus <= 16'h0123;
    waitHalt(1'b1, "address hit");
    addrBus <= 16'h0000;
    send(8'h40, 1'b1);
    chk(replyByte[1] === 1'b1, "hit flag");
    send(8'h21, 1'b0);
    // Data area SRAM with value compare; wrong value first
    valEnable <= 1'b1;
    send(8'h35, 1'b0);
    dataAccess <= 1'b1;
    dataArea <= 2'h1;
    addrBus <= 16'h0123;
    repeat (20) @(posedge core_clk);
    chk(coreHalted === 1'b0 && cfgError === 1'b0, "value miss");
    dataBus <= 8'hA5;
    waitHalt(1'b1, "data hit");
    dataAccess <= 1'b0;
    send(8'h21, 1'b0);
    // Program type mixed with value compare is refused
    send(8'h30, 1'b0);
    #8 chk(cfgError === 1'b1, "mixed config");
    repeat (20) @(posedge core_clk);
    chk(coreHalted === 1'b0, "refused config hit");
    @(posedge core_clk) breakInsn <= 1'b1;
    @(posedge core_clk) breakInsn <= 1'b0;
    waitHalt(1'b1, "break halt");
    // Program address range over both comparators
    addrBus <= 16'h0000;
    valEnable <= 1'b0;
    cmpAddr1 <= 16'h0200;
    addrEnable <= 2'b11;
    send(8'h21, 1'b0);
    send(8'h38, 1'b0);
    chk(coreHalted === 1'b0 && cfgError === 1'b0, "range idle");
    addrBus <= 16'h0150;
    waitHalt(1'b1, "range hit");
    addrEnable <= 2'b01;
    repeat (2) @(posedge core_clk);
    #1 chk(cfgError === 1'b1, "range with second breakpoint");
    finish_test();
  end
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule // tb_ocd_stop_mode_breakpoints
